// >>> hdl/reset_wakeup_window_watchdog.sv
// Function
// - lin driver off on fault, back when recessive
// - reset pin low while source active
// - reset low further 1.0 ms after source
// - reset from supply, watchdog, sleep wake, pin
// - regulator overtemp disables regulator, sets flag
// - sleep wake runs full reset sequence
// - external reset pin forces reset state, except in sleep
// - external reset ends without extension
// - stop wake irq, sleep wake reset; recorded
// - no record for chip select, pin wake
// - wake line enable bit; line state readable
// - line in analog mux blocks its wake
// - cyclic sense pulses outputs, samples line
// - cyclic sense or forced wake, exclusive
// - chip select rising edge wakes from stop
// - lin wake: long dominant then recessive
// - receive only blocks lin wake in stop
// - pin wake from stop to normal request
// - mode bits write clears the watchdog
// - closed half clear or timeout resets host
// - grounded strap disables watchdog, sampled in reset
// - open strap uses internal 150 ms timebase
// - prescaler divides; 150 ms normal request timeout
// - irq low until source register read, high while reset is driven
`timescale 1ns/1ps
`include "rww_consts.svh"

module reset_wakeup_window_watchdog #(
	parameter int unsigned EXT_CYC        = `T_RST_EXT_US * `CLK_MHZ,
	parameter int unsigned NREQ_CYC       = `T_NREQ_MS * 1000 * `CLK_MHZ,
	parameter int unsigned WD_INT_CYC     = `T_WD_INT_MS * 1000 * `CLK_MHZ,
	parameter int unsigned WD_RES_CYC     = `T_WD_RES_MS * 1000 * `CLK_MHZ,
	parameter int unsigned SENSE_BASE_CYC = `T_SENSE_BASE_MS * 1000 * `CLK_MHZ
) (
	input  wire logic        clock_i,                     // system clock
	input  wire logic        rst_i,                       // synchronous reset
	input  wire logic        vdd_low_i,                   // supply below reset threshold
	input  wire logic        reg_overtemp_i,              // regulator overtemperature
	input  wire logic        lin_overtemp_i,              // lin driver overtemperature
	input  wire logic        txd_dom_fault_i,             // transmit stuck dominant
	input  wire logic        rxd_short_i,                 // receive line short
	input  wire logic        txd_i,                       // transmit input, high recessive
	input  wire logic        rst_pin_i,                   // reset pin level
	input  wire logic        cs_i,                        // spi chip select level
	input  wire logic        lin_rx_i,                    // lin bus level, low dominant
	input  wire logic        wake_input_line_i,           // wake input line level
	input  wire logic        wake_line_enable_i,          // wake line enable bit
	input  wire logic        wake_line_in_mux_i,          // line routed to analog mux
	input  wire logic [1:0]  high_side_enable_i,          // high side enable bits
	input  wire logic        cyclic_or_watchdog_select_i, // timer enable bit
	input  wire logic [1:0]  sense_period_field_i,        // sense period select
	input  wire logic [1:0]  wd_prescale_i,               // watchdog prescaler
	input  wire logic        receive_only_bit_i,          // lin receive only bit
	input  wire logic        watchdog_strap_gnd_i,        // strap pin grounded
	input  wire logic        watchdog_strap_res_i,        // strap resistor found
	input  wire logic        mode_bits_write_i,           // spi write to mode bits
	input  wire logic        cmd_normal_i,                // command normal mode
	input  wire logic        cmd_stop_i,                  // command stop mode
	input  wire logic        cmd_sleep_i,                 // command sleep mode
	input  wire logic        int_src_read_i,              // source register read
	output logic             rst_pin_o,                   // reset pin drive level
	output logic             rst_pin_oe_o,                // reset pin drive enable
	output logic             irq_n_o,                     // interrupt, active low
	output logic             lin_driver_en_o,             // lin driver enable
	output logic             regulator_en_o,              // regulator enable
	output logic             regulator_overtemp_flag_o,   // regulator overtemp flag
	output logic             watchdog_off_flag_o,         // watchdog strapped off
	output logic             watchdog_fault_flag_o,       // strap open, internal base
	output logic             wake_line_state_o,           // wake line state
	output logic [1:0]       high_side_output_o,          // high side drive
	output logic [2:0]       wake_source_o,               // wake source record
	output rww_pkg::mode_t   mode_o                       // operating mode
);
	import rww_pkg::*;

	localparam int W = `CNT_W;

	function automatic logic is_low_power(input mode_t m);
		return (m == ST_STOP) || (m == ST_SLEEP);
	endfunction

	logic [3:0]   sync1;
	logic [3:0]   sync2;
	logic         cs_d;
	logic [2:0]   own_hist;
	logic [7:0]   filt_cnt;
	logic         ext_rst;
	logic [W-1:0] ext_cnt;
	logic         wd_fail_q;
	logic         nreq_to_q;
	logic         sleep_wake_q;
	logic [W-1:0] wd_cnt;
	logic [W-1:0] nreq_cnt;
	logic [W-1:0] lp_cnt;
	logic [7:0]   lin_cnt;
	logic         lin_armed;
	logic         line_ref;
	logic         mux_block;
	logic         irq_pend;
	logic         lp;
	logic         int_src;
	logic         rst_drive;
	logic         cs_rise;
	logic         cyclic;
	logic         timer_end;
	logic         wake_line;
	logic         wake_lin;
	logic         wake_timer;
	logic [2:0]   wake_set;
	logic [W-1:0] wd_limit;
	logic [W-1:0] wd_half;
	logic [W-1:0] sense_period;
	logic         lin_fault;

	// synchronisers: {cs, lin, line, reset pin}
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sync1 <= `SYNC_IDLE;
			sync2 <= `SYNC_IDLE;
			cs_d  <= 1'b1;
		end else begin
			sync1 <= {cs_i, lin_rx_i, wake_input_line_i, rst_pin_i};
			sync2 <= sync1;
			cs_d  <= sync2[3];
		end
	end

	assign lp      = is_low_power(mode_o);
	assign cs_rise = sync2[3] & ~cs_d;

	// external reset filter; own drive and its echo are masked
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			own_hist <= 3'h0;
			filt_cnt <= 8'h00;
			ext_rst  <= 1'b0;
		end else begin
			own_hist <= {own_hist[1:0], rst_pin_oe_o};
			if (sync2[0] || (|own_hist) || rst_pin_oe_o || mode_o == ST_SLEEP) begin
				filt_cnt <= 8'h00;
				ext_rst  <= 1'b0;
			end else if (filt_cnt == 8'(`RST_FILT_CYC - 1)) begin
				ext_rst <= 1'b1;
			end else begin
				filt_cnt <= filt_cnt + 8'h01;
			end
		end
	end

	// internal sources and the extended low period
	assign int_src = (vdd_low_i && mode_o != ST_SLEEP) | wd_fail_q | nreq_to_q
		| sleep_wake_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ext_cnt <= W'(EXT_CYC);
		end else if (int_src) begin // external low never loads it
			ext_cnt <= W'(EXT_CYC);
		end else if (ext_cnt != '0) begin
			ext_cnt <= ext_cnt - W'(1);
		end
	end

	assign rst_drive    = int_src | (ext_cnt != '0);
	assign rst_pin_oe_o = rst_drive;
	assign rst_pin_o    = 1'b0;

	// strap sampling happens only in reset mode
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			watchdog_off_flag_o   <= 1'b0;
			watchdog_fault_flag_o <= 1'b0;
		end else if (mode_o == ST_RESET) begin
			watchdog_off_flag_o   <= watchdog_strap_gnd_i;
			watchdog_fault_flag_o <= !watchdog_strap_gnd_i && !watchdog_strap_res_i;
		end
	end

	// window watchdog
	assign wd_limit = (watchdog_fault_flag_o ? W'(WD_INT_CYC) : W'(WD_RES_CYC))
		>> wd_prescale_i;
	assign wd_half  = wd_limit >> 1;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wd_cnt    <= '0;
			wd_fail_q <= 1'b0;
		end else if (mode_o == ST_NORMAL && !watchdog_off_flag_o && !wd_fail_q) begin
			wd_fail_q <= (mode_bits_write_i && wd_cnt < wd_half)
				|| (!mode_bits_write_i && wd_cnt >= wd_limit - W'(1));
			wd_cnt    <= mode_bits_write_i ? '0 : wd_cnt + W'(1);
		end else begin
			wd_cnt    <= '0;
			wd_fail_q <= 1'b0;
		end
	end

	// normal request timeout
	always_ff @(posedge clock_i) begin
		if (rst_i || mode_o != ST_NORM_REQ) begin
			nreq_cnt  <= '0;
			nreq_to_q <= 1'b0;
		end else begin
			nreq_cnt  <= nreq_cnt + W'(1);
			nreq_to_q <= !cmd_normal_i && nreq_cnt == W'(NREQ_CYC - 1);
		end
	end

	// low power timer: cyclic sense or forced wake
	assign cyclic       = cyclic_or_watchdog_select_i && (|high_side_enable_i);
	assign sense_period = W'(SENSE_BASE_CYC) << sense_period_field_i;
	assign timer_end    = lp && cyclic_or_watchdog_select_i && lp_cnt == '0;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lp_cnt             <= '0;
			line_ref           <= 1'b0;
			mux_block          <= 1'b0;
			high_side_output_o <= 2'h0;
			wake_line_state_o  <= 1'b0;
		end else begin
			wake_line_state_o <= sync2[1];
			if (!lp) begin
				lp_cnt    <= sense_period - W'(1);
				line_ref  <= sync2[1];
				mux_block <= wake_line_in_mux_i;
			end else begin
				lp_cnt <= (lp_cnt == '0) ? sense_period - W'(1) : lp_cnt - W'(1);
				if (!cyclic) begin
					line_ref <= line_ref;
				end else if (timer_end) begin
					line_ref <= sync2[1];
				end
			end
			high_side_output_o <= (lp && cyclic && lp_cnt < W'(`HS_ON_CYC))
				? high_side_enable_i : 2'h0;
		end
	end

	// lin wake filter
	always_ff @(posedge clock_i) begin
		if (rst_i || !lp || sync2[2]) begin
			lin_cnt   <= 8'h00;
			lin_armed <= 1'b0;
		end else if (lin_cnt == 8'(`LIN_FILT_CYC)) begin
			lin_armed <= 1'b1;
		end else begin
			lin_cnt <= lin_cnt + 8'h01;
		end
	end

	assign wake_line  = lp && wake_line_enable_i && !mux_block && sync2[1] != line_ref
		&& (!cyclic || timer_end);
	assign wake_timer = timer_end && !cyclic;
	assign wake_lin   = lp && lin_armed && sync2[2]
		&& !(mode_o == ST_STOP && receive_only_bit_i);

	// chip select and pin wakes leave no record
	always_comb begin
		wake_set = 3'h0;
		wake_set[`WAKE_LINE_BIT]  = wake_line;
		wake_set[`WAKE_LIN_BIT]   = wake_lin;
		wake_set[`WAKE_TIMER_BIT] = wake_timer;
	end

	// source record and interrupt; a new event wins over the read
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wake_source_o <= 3'h0;
			irq_pend      <= 1'b0;
			sleep_wake_q  <= 1'b0;
		end else begin
			wake_source_o <= (int_src_read_i ? 3'h0 : wake_source_o) | wake_set;
			irq_pend      <= (irq_pend && !int_src_read_i)
				|| (mode_o == ST_STOP && (|wake_set));
			sleep_wake_q  <= mode_o == ST_SLEEP && (|wake_set);
		end
	end

	assign irq_n_o = !(irq_pend && !rst_drive);

	// fault protection
	assign lin_fault = lin_overtemp_i || txd_dom_fault_i || rxd_short_i;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lin_driver_en_o           <= 1'b0;
			regulator_en_o            <= 1'b1;
			regulator_overtemp_flag_o <= 1'b0;
		end else begin
			if (lin_fault) begin
				lin_driver_en_o <= 1'b0;
			end else if (txd_i) begin
				lin_driver_en_o <= 1'b1;
			end
			regulator_en_o            <= !reg_overtemp_i && mode_o != ST_SLEEP;
			regulator_overtemp_flag_o <= reg_overtemp_i;
		end
	end

	// operating mode
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mode_o <= ST_RESET;
		end else if (mode_o != ST_SLEEP && (rst_drive || ext_rst)) begin
			mode_o <= ST_RESET;
		end else begin
			case (mode_o)
				ST_RESET: begin
					if (regulator_overtemp_flag_o) begin
						mode_o <= ST_SLEEP;
					end else begin
						mode_o <= watchdog_strap_gnd_i ? ST_NORMAL : ST_NORM_REQ;
					end
				end
				ST_NORM_REQ: begin
					if (cmd_normal_i) begin
						mode_o <= ST_NORMAL;
					end
				end
				ST_NORMAL: begin
					if (cmd_sleep_i) begin
						mode_o <= ST_SLEEP;
					end else if (cmd_stop_i) begin
						mode_o <= ST_STOP;
					end
				end
				ST_STOP: begin
					if ((|wake_set) || cs_rise) begin
						mode_o <= watchdog_off_flag_o ? ST_NORMAL : ST_NORM_REQ;
					end
				end
				ST_SLEEP: begin
					if (|wake_set) begin
						mode_o <= ST_RESET;
					end
				end
				default: begin
					mode_o <= ST_RESET;
				end
			endcase
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	AST_LIN_OFF: assert property (lin_fault |=> !lin_driver_en_o)
		else $error("lin driver still enabled after fault");
	AST_LIN_BACK: assert property (!lin_fault && txd_i |=> lin_driver_en_o)
		else $error("lin driver not restored");
	AST_RST_HOLD: assert property (int_src |-> rst_pin_oe_o ##1 rst_pin_oe_o)
		else $error("reset released while source active");
	AST_RST_EXT: assert property ($fell(int_src) |-> rst_pin_oe_o [*8])
		else $error("reset released too early");
	AST_REG_OT: assert property (reg_overtemp_i
		|=> !regulator_en_o && regulator_overtemp_flag_o)
		else $error("regulator not shut down");
	AST_SLEEP_WAKE: assert property (mode_o == ST_SLEEP && (|wake_set)
		|=> (mode_o == ST_RESET && rst_pin_oe_o) ##1 rst_pin_oe_o)
		else $error("sleep wake without reset");
	AST_EXT_RST: assert property (ext_rst && mode_o != ST_SLEEP |=> mode_o == ST_RESET)
		else $error("external reset not honoured");
	AST_NO_EXTRA: assert property (ext_rst && !int_src && ext_cnt == '0
		|=> !rst_pin_oe_o || int_src)
		else $error("extension after external reset");
	AST_STOP_IRQ: assert property (mode_o == ST_STOP && (|wake_set)
		|=> !irq_n_o || rst_pin_oe_o)
		else $error("stop wake without interrupt");
	AST_CS_WAKE: assert property (mode_o == ST_STOP && cs_rise && !(|wake_set) && !irq_pend
		|=> irq_n_o && mode_o != ST_STOP && $stable(wake_source_o))
		else $error("chip select wake wrong");
	AST_WD_CLOSED: assert property (mode_o == ST_NORMAL && !watchdog_off_flag_o
		&& !wd_fail_q && mode_bits_write_i && wd_cnt < wd_half
		|=> rst_pin_oe_o [*3])
		else $error("closed window clear not punished");
	AST_NREQ_TO: assert property (mode_o == ST_NORM_REQ && !cmd_normal_i
		&& nreq_cnt == W'(NREQ_CYC - 1)
		|=> rst_pin_oe_o ##1 mode_o == ST_RESET)
		else $error("normal request timeout missed");
	AST_WD_OFF: assert property (mode_o == ST_RESET && !rst_drive && !ext_rst
		&& watchdog_strap_gnd_i && !regulator_overtemp_flag_o
		|=> mode_o == ST_NORMAL && watchdog_off_flag_o)
		else $error("strapped off watchdog not skipped");

	COV_SLEEP_WAKE: cover property (mode_o == ST_SLEEP && wake_line);
	COV_STOP_LIN: cover property (mode_o == ST_STOP && wake_lin ##1 !irq_n_o);
	COV_WD_FAIL: cover property (wd_fail_q);
	COV_CS_WAKE: cover property (mode_o == ST_STOP && cs_rise);
endmodule

// >>> hdl/rww_consts.svh
`ifndef RWW_CONSTS_SVH
`define RWW_CONSTS_SVH

// clock rate and printed times
`define CLK_MHZ         50
`define T_RST_EXT_US    1000
`define T_NREQ_MS       150
`define T_WD_INT_MS     150
`define T_WD_RES_MS     100
`define T_SENSE_BASE_MS 10

// short filters and windows, in clock cycles
`define RST_FILT_CYC    16
`define LIN_FILT_CYC    150
`define HS_ON_CYC       50

`define CNT_W           24

// wake source record bit positions
`define WAKE_LINE_BIT   0
`define WAKE_LIN_BIT    1
`define WAKE_TIMER_BIT  2

// synchroniser reset value, all pins idle high
`define SYNC_IDLE       4'hF

`endif

// >>> hdl/rww_pkg.sv
package rww_pkg;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_NORM_REQ,
		ST_NORMAL,
		ST_STOP,
		ST_SLEEP
	} mode_t;

endpackage

// >>> sim/host_model.sv
`timescale 1ns/1ps

module host_model #(
	parameter int unsigned ACK_DLY = 3
) (
	input  wire logic clock_i,        // system clock
	input  wire logic dev_rst_oe_i,   // device pulls the reset wire low
	input  wire logic irq_n_i,        // interrupt wire, active low
	input  wire logic pull_rst_i,     // host holds the reset wire low
	input  wire logic ack_en_i,       // host services interrupts
	output logic      rst_wire_o,     // reset wire, pulled up when released
	output logic      int_src_read_o  // source register read pulse
);
	int unsigned wait_cnt = 0;

	// open drain wire with pull-up: low while either side pulls
	assign rst_wire_o = !(dev_rst_oe_i || pull_rst_i);

	initial int_src_read_o = 1'b0;

	// read the source register a few cycles after the wire drops
	always @(posedge clock_i) begin
		int_src_read_o <= 1'b0;
		if (irq_n_i || !ack_en_i) begin
			wait_cnt <= 0;
		end else if (wait_cnt == ACK_DLY) begin
			int_src_read_o <= 1'b1;
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

// >>> sim/reset_wakeup_window_watchdog_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module reset_wakeup_window_watchdog_tb;
	import rww_pkg::*;
	localparam int unsigned EXT = 20;
	typedef struct packed {logic ot; logic dom; logic sh; logic txd; logic en;} lin_row_t;
	localparam lin_row_t ROWS [7] = '{5'h12, 5'h03, 5'h08, 5'h00, 5'h03, 5'h06, 5'h03};

	logic       clock_i, rst_i, vdd_low_i, reg_overtemp_i, lin_overtemp_i, txd_dom_fault_i;
	logic       rxd_short_i, txd_i, cs_i, lin_rx_i, wake_input_line_i, wake_line_enable_i;
	logic       cyclic_or_watchdog_select_i, receive_only_bit_i, mode_bits_write_i;
	logic       cmd_normal_i, cmd_stop_i, cmd_sleep_i, pull_rst, ack_en, rst_wire, int_src_read;
	logic       rst_pin_o, rst_pin_oe_o, irq_n_o, lin_driver_en_o, regulator_en_o;
	logic       reg_ot_flag, wd_off, wd_fault, wake_line_state_o;
	logic       wake_line_in_mux_i, watchdog_strap_gnd_i, watchdog_strap_res_i;
	logic [1:0] wd_prescale_i;
	logic [1:0] high_side_enable_i, sense_period_field_i;
	logic [1:0] hs_out;
	logic [2:0] wake_source_o;
	mode_t      mode_o;
	int         err_total;
	int         checks_done;
	int         n;

	reset_wakeup_window_watchdog #(.EXT_CYC(EXT), .NREQ_CYC(200), .WD_INT_CYC(400),
		.WD_RES_CYC(300), .SENSE_BASE_CYC(100)) reset_wakeup_window_watchdog_i (
		.clock_i(clock_i), .rst_i(rst_i), .vdd_low_i(vdd_low_i), .reg_overtemp_i(reg_overtemp_i),
		.lin_overtemp_i(lin_overtemp_i), .txd_dom_fault_i(txd_dom_fault_i),
		.rxd_short_i(rxd_short_i), .txd_i(txd_i), .rst_pin_i(rst_wire), .cs_i(cs_i),
		.lin_rx_i(lin_rx_i), .wake_input_line_i(wake_input_line_i),
		.wake_line_enable_i(wake_line_enable_i), .wake_line_in_mux_i(wake_line_in_mux_i),
		.high_side_enable_i(high_side_enable_i),
		.cyclic_or_watchdog_select_i(cyclic_or_watchdog_select_i),
		.sense_period_field_i(sense_period_field_i), .wd_prescale_i(wd_prescale_i),
		.receive_only_bit_i(receive_only_bit_i), .watchdog_strap_gnd_i(watchdog_strap_gnd_i),
		.watchdog_strap_res_i(watchdog_strap_res_i), .mode_bits_write_i(mode_bits_write_i),
		.cmd_normal_i(cmd_normal_i), .cmd_stop_i(cmd_stop_i), .cmd_sleep_i(cmd_sleep_i),
		.int_src_read_i(int_src_read), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
		.irq_n_o(irq_n_o), .lin_driver_en_o(lin_driver_en_o), .regulator_en_o(regulator_en_o),
		.regulator_overtemp_flag_o(reg_ot_flag), .watchdog_off_flag_o(wd_off),
		.watchdog_fault_flag_o(wd_fault), .wake_line_state_o(wake_line_state_o),
		.high_side_output_o(hs_out), .wake_source_o(wake_source_o), .mode_o(mode_o));

	host_model host_model_i (.clock_i(clock_i), .dev_rst_oe_i(rst_pin_oe_o), .irq_n_i(irq_n_o),
		.pull_rst_i(pull_rst), .ack_en_i(ack_en), .rst_wire_o(rst_wire),
		.int_src_read_o(int_src_read));

	task automatic report_and_stop();
		if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clock_i);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask

	task automatic wait_mode(input mode_t m, input int lim, input string nm);
		int i;
		i = 0;
		while (mode_o !== m && i < lim) begin
			tick(1);
			i++;
		end
		`CHK(nm, m, mode_o)
	endtask

	task automatic oe_len(output int k);
		k = 0;
		while (rst_pin_oe_o === 1'b1 && k < 1000) begin
			tick(1);
			k++;
		end
	endtask

	task automatic to_normal();
		pulse(cmd_normal_i);
		wait_mode(ST_NORMAL, 3, "normal");
	endtask

	task automatic to_low(ref logic c, input mode_t m);
		to_normal();
		pulse(c);
		wait_mode(m, 3, "enter_low");
	endtask

	task automatic lin_pulse(input int k);
		lin_rx_i = 1'b0;
		tick(k);
		lin_rx_i = 1'b1;
		tick(12);
	endtask

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end

	initial begin
		{vdd_low_i, reg_overtemp_i, lin_overtemp_i, txd_dom_fault_i, rxd_short_i} = '0;
		{cyclic_or_watchdog_select_i, receive_only_bit_i, mode_bits_write_i} = '0;
		{cmd_normal_i, cmd_stop_i, cmd_sleep_i, pull_rst, ack_en, wake_line_enable_i} = '0;
		{txd_i, cs_i, lin_rx_i} = 3'h7;
		wake_input_line_i = 1'b0;
		wd_prescale_i = 2'h1;
		{wake_line_in_mux_i, watchdog_strap_gnd_i} = 2'h0;
		watchdog_strap_res_i = 1'b1;
		{high_side_enable_i, sense_period_field_i} = 4'h0;
		err_total = 0;
		checks_done = 0;
		rst_i = 1'b1;
		tick(10);
		rst_i = 1'b0;
		tick(1);
		oe_len(n);
		`CHK("ext_len", 1'b1, n >= EXT - 2 && n <= EXT + 2)
		wait_mode(ST_NORM_REQ, 5, "nreq");
		`CHK("wd_flags", 2'h0, {wd_off, wd_fault})
		foreach (ROWS[i]) begin
			{lin_overtemp_i, txd_dom_fault_i, rxd_short_i, txd_i} = ROWS[i][4:1];
			tick(3);
			`CHK("lin_en", ROWS[i].en, lin_driver_en_o)
		end
		wait_mode(ST_RESET, 250, "nreq_timeout");
		wait_mode(ST_NORM_REQ, EXT + 10, "nreq_again");
		// window: limit 150 with prescale 1, closed below 75
		to_normal();
		tick(100);
		pulse(mode_bits_write_i);
		tick(3);
		`CHK("wd_open", 1'b0, rst_pin_oe_o)
		tick(30);
		pulse(mode_bits_write_i);
		tick(2);
		`CHK("wd_closed", 1'b1, rst_pin_oe_o)
		wait_mode(ST_NORM_REQ, EXT + 10, "wd_recover");
		to_normal();
		wait_mode(ST_RESET, 170, "wd_overflow");
		wait_mode(ST_NORM_REQ, EXT + 10, "wd_recover2");
		wake_line_enable_i = 1'b1;
		to_low(cmd_stop_i, ST_STOP);
		wake_input_line_i = 1'b1;
		wait_mode(ST_NORM_REQ, 10, "line_wake");
		tick(2);
		`CHK("line_irq", 4'h1, {irq_n_o, wake_source_o})
		`CHK("line_state", 1'b1, wake_line_state_o)
		tick(8);
		`CHK("irq_held", 1'b0, irq_n_o)
		ack_en = 1'b1;
		tick(8);
		`CHK("irq_ack", 4'h8, {irq_n_o, wake_source_o})
		ack_en = 1'b0;
		wake_line_enable_i = 1'b0;
		to_low(cmd_stop_i, ST_STOP);
		wake_input_line_i = 1'b0;
		tick(10);
		`CHK("line_off", ST_STOP, mode_o)
		cs_i = 1'b0;
		tick(3);
		cs_i = 1'b1;
		wait_mode(ST_NORM_REQ, 10, "cs_wake");
		tick(2);
		`CHK("cs_quiet", 4'h8, {irq_n_o, wake_source_o})
		receive_only_bit_i = 1'b1;
		to_low(cmd_stop_i, ST_STOP);
		lin_pulse(200);
		`CHK("rx_only", ST_STOP, mode_o)
		receive_only_bit_i = 1'b0;
		lin_pulse(100);
		`CHK("lin_short", ST_STOP, mode_o)
		lin_pulse(200);
		`CHK("lin_wake", 4'h2, {irq_n_o, wake_source_o})
		ack_en = 1'b1;
		tick(8);
		ack_en = 1'b0;
		to_normal();
		pull_rst = 1'b1;
		wait_mode(ST_RESET, 25, "ext_rst");
		tick(10);
		`CHK("ext_hold", ST_RESET, mode_o)
		pull_rst = 1'b0;
		wait_mode(ST_NORM_REQ, 8, "ext_release");
		to_low(cmd_stop_i, ST_STOP);
		pull_rst = 1'b1;
		tick(22);
		pull_rst = 1'b0;
		wait_mode(ST_NORM_REQ, 30, "rst_wake");
		`CHK("rst_quiet", 4'h8, {irq_n_o, wake_source_o})
		vdd_low_i = 1'b1;
		tick(5);
		`CHK("vdd_drive", 1'b1, rst_pin_oe_o)
		`CHK("rst_level", 1'b0, rst_pin_o)
		vdd_low_i = 1'b0;
		oe_len(n);
		`CHK("vdd_ext", 1'b1, n >= EXT - 2 && n <= EXT + 2)
		wait_mode(ST_NORM_REQ, 5, "vdd_recover");
		// line routed to the mux at entry stays blocked for the whole stop
		wake_line_enable_i = 1'b1;
		wake_line_in_mux_i = 1'b1;
		to_low(cmd_stop_i, ST_STOP);
		wake_input_line_i = 1'b1;
		wake_line_in_mux_i = 1'b0;
		tick(10);
		`CHK("mux_block", ST_STOP, mode_o)
		cs_i = 1'b0;
		tick(3);
		cs_i = 1'b1;
		wait_mode(ST_NORM_REQ, 10, "mux_exit");
		// cyclic sense: period 200, high side on for the last 50 cycles
		{high_side_enable_i, sense_period_field_i} = 4'h9;
		cyclic_or_watchdog_select_i = 1'b1;
		to_low(cmd_stop_i, ST_STOP);
		wake_input_line_i = 1'b0;
		tick(100);
		`CHK("cyc_wait", ST_STOP, mode_o)
		`CHK("hs_idle", 2'h0, hs_out)
		tick(60);
		`CHK("hs_on", 2'h2, hs_out)
		wait_mode(ST_NORM_REQ, 50, "cyc_wake");
		`CHK("cyc_src", 4'h1, {irq_n_o, wake_source_o})
		ack_en = 1'b1;
		tick(8);
		ack_en = 1'b0;
		{high_side_enable_i, sense_period_field_i} = 4'h0;
		wake_line_enable_i = 1'b0;
		cyclic_or_watchdog_select_i = 1'b1;
		to_low(cmd_sleep_i, ST_SLEEP);
		wait_mode(ST_RESET, 120, "sleep_wake");
		tick(2);
		`CHK("sleep_rst", 4'hC, {rst_pin_oe_o, wake_source_o})
		cyclic_or_watchdog_select_i = 1'b0;
		wait_mode(ST_NORM_REQ, EXT + 10, "sleep_recover");
		// grounded strap: straight to normal, watchdog never fires
		watchdog_strap_gnd_i = 1'b1;
		vdd_low_i = 1'b1;
		tick(2);
		vdd_low_i = 1'b0;
		wait_mode(ST_NORMAL, EXT + 10, "strap_gnd");
		tick(200);
		`CHK("wd_off_mode", ST_NORMAL, mode_o)
		`CHK("wd_off_flag", 1'b1, wd_off)
		// open strap: internal base, limit 400 >> 1
		{watchdog_strap_gnd_i, watchdog_strap_res_i} = 2'h0;
		vdd_low_i = 1'b1;
		tick(2);
		vdd_low_i = 1'b0;
		wait_mode(ST_NORM_REQ, EXT + 10, "strap_open");
		`CHK("wd_int_flag", 2'h1, {wd_off, wd_fault})
		to_normal();
		tick(190);
		`CHK("wd_int_base", ST_NORMAL, mode_o)
		wait_mode(ST_RESET, 20, "wd_int_over");
		watchdog_strap_res_i = 1'b1;
		wait_mode(ST_NORM_REQ, EXT + 10, "strap_res");
		reg_overtemp_i = 1'b1;
		tick(3);
		`CHK("reg_ot", 2'h1, {regulator_en_o, reg_ot_flag})
		report_and_stop();
	end
endmodule
